// file: hw/dram_termination_control.sv
// Contract
// - termination turns on wl-2 link cycles after odt sampled high
// - termination turns off wl-2 link cycles after odt registered low
// - switch-off and strength changes take effect half a link cycle later
// - termination never turns on while the data drivers are active
// - dynamic switching active when either write strength bit is one
// - nominal value from three nominal bits, write value from two write bits
// - outside writes nominal strength used, on/off follows odt latencies
// - write strength selected wl-2 cycles after the newest registered write
// - nominal strength returns off latency plus four or six after write
// - odt ignored when nominal and write strength bits are all zero
module dram_termination_control (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [odt_pkg::ADDR_W-1:0] regAddr,
  input wire logic [odt_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [odt_pkg::DATA_W-1:0] regRdData,
  input wire logic linkClk,
  input wire logic odtPin,
  input wire logic writeCmdPin,
  input wire logic burstSelPin,
  input wire logic dqDriving,
  output logic termActive,
  output logic strengthWrite,
  output logic [odt_pkg::NOM_W-1:0] rttSetting
);
  import odt_pkg::*;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  // only the edges of the link clock are used, not its level
  logic ckRise;
  logic ckFall;
  logic odtLevel;
  logic wrLevel;
  logic burstLevel;

  pin_sync ckSync (.core_clk(core_clk), .rstn(rstn), .pinIn(linkClk),
    .level(), .rise(ckRise), .fall(ckFall));
  pin_sync odtSync (.core_clk(core_clk), .rstn(rstn), .pinIn(odtPin),
    .level(odtLevel), .rise(), .fall());
  pin_sync wrSync (.core_clk(core_clk), .rstn(rstn), .pinIn(writeCmdPin),
    .level(wrLevel), .rise(), .fall());
  pin_sync burstSync (.core_clk(core_clk), .rstn(rstn), .pinIn(burstSelPin),
    .level(burstLevel), .rise(), .fall());

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [NOM_W-1:0] nomCode_reg, nomCode_next;
  logic [WRC_W-1:0] wrCode_reg, wrCode_next;
  logic [CFG_W-1:0] cwl_reg, cwl_next;
  logic [CFG_W-1:0] al_reg, al_next;
  logic [1:0] burst_reg, burst_next;
  logic [DATA_W-1:0] rdData_reg, rdData_next;
  logic [STAT_W-1:0] status;

  // write decode and read mux, unmapped reads return zero
  always_comb begin
    nomCode_next = nomCode_reg;
    wrCode_next = wrCode_reg;
    cwl_next = cwl_reg;
    al_next = al_reg;
    burst_next = burst_reg;
    rdData_next = '0;
    if (regWrite) begin
      case (regAddr)
        OFF_NOM_CODE: nomCode_next = regWrData[NOM_W-1:0];
        OFF_WR_CODE: wrCode_next = regWrData[WRC_W-1:0];
        OFF_CWL: cwl_next = regWrData[CFG_W-1:0];
        OFF_AL: al_next = regWrData[CFG_W-1:0];
        OFF_BURST: burst_next = regWrData[1:0];
        default: ;
      endcase
    end
    if (regRead) begin
      case (regAddr)
        OFF_NOM_CODE: rdData_next = {{(DATA_W-NOM_W){1'b0}}, nomCode_reg};
        OFF_WR_CODE: rdData_next = {{(DATA_W-WRC_W){1'b0}}, wrCode_reg};
        OFF_CWL: rdData_next = {{(DATA_W-CFG_W){1'b0}}, cwl_reg};
        OFF_AL: rdData_next = {{(DATA_W-CFG_W){1'b0}}, al_reg};
        OFF_BURST: rdData_next = {{(DATA_W-2){1'b0}}, burst_reg};
        OFF_STATUS: rdData_next = {{(DATA_W-STAT_W){1'b0}}, status};
        default: rdData_next = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      nomCode_reg <= RST_NOM_CODE;
      wrCode_reg <= RST_WR_CODE;
      cwl_reg <= RST_CWL;
      al_reg <= RST_AL;
      burst_reg <= RST_BURST;
      rdData_reg <= '0;
    end else begin
      nomCode_reg <= nomCode_next;
      wrCode_reg <= wrCode_next;
      cwl_reg <= cwl_next;
      al_reg <= al_next;
      burst_reg <= burst_next;
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;

  // ----------------------------------------------------------------
  // mode decode and latencies
  // ----------------------------------------------------------------
  logic odtEnable;
  logic dynEnable;
  logic [LAT_W-1:0] termLat;

  // termination latency = cwl + al - 2, never below one cycle
  function automatic logic [LAT_W-1:0] calc_lat(input logic [CFG_W-1:0] cwl,
                                                input logic [CFG_W-1:0] al);
    logic [LAT_W-1:0] sum;
    sum = LAT_W'(cwl) + LAT_W'(al);
    if (sum > LAT_OFFSET) begin
      calc_lat = sum - LAT_OFFSET;
    end else begin
      calc_lat = 6'h01;
    end
  endfunction : calc_lat

  assign odtEnable = (|nomCode_reg) | (|wrCode_reg);
  assign dynEnable = |wrCode_reg;
  assign termLat = calc_lat(cwl_reg, al_reg);

  // ----------------------------------------------------------------
  // termination on/off pipeline
  // ----------------------------------------------------------------
  logic [AGE_IDLE:0] odtHist_reg, odtHist_next;
  logic termPend_reg, termPend_next;
  logic termOn_reg, termOn_next;
  logic delayedOdt;

  assign delayedOdt = odtHist_reg[termLat - 6'h01];

  // pending state decided on link rise, on at rise, off at next fall
  always_comb begin
    odtHist_next = odtHist_reg;
    termPend_next = termPend_reg;
    termOn_next = termOn_reg;
    if (ckRise) begin
      odtHist_next = {odtHist_reg[AGE_IDLE-1:0], odtLevel};
      termPend_next = delayedOdt & odtEnable;
      if (delayedOdt && odtEnable) begin
        termOn_next = 1'b1;
      end
    end else if (ckFall && !termPend_reg) begin
      termOn_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      odtHist_reg <= '0;
      termPend_reg <= 1'b0;
      termOn_reg <= 1'b0;
    end else begin
      odtHist_reg <= odtHist_next;
      termPend_reg <= termPend_next;
      termOn_reg <= termOn_next;
    end
  end

  // ----------------------------------------------------------------
  // dynamic strength switching
  // ----------------------------------------------------------------
  logic [LAT_W-1:0] wrAge_reg, wrAge_next;
  logic chop_reg, chop_next;
  logic wrSelPend_reg, wrSelPend_next;
  logic wrSel_reg, wrSel_next;
  logic [LAT_W-1:0] retLat;
  logic wrChop;

  assign wrChop = (burst_reg == BURST_FIXED4) | ((burst_reg == BURST_OTF) & ~burstLevel);
  assign retLat = termLat + (chop_reg ? TAIL_CHOP : TAIL_FULL);

  // write age counts link cycles since the newest write
  always_comb begin
    wrAge_next = wrAge_reg;
    chop_next = chop_reg;
    wrSelPend_next = wrSelPend_reg;
    wrSel_next = wrSel_reg;
    if (ckRise) begin
      if (wrLevel) begin
        wrAge_next = '0;
        chop_next = wrChop;
      end else if (wrAge_reg != AGE_IDLE) begin
        wrAge_next = wrAge_reg + 6'h01;
      end
      if (wrAge_next == termLat) begin
        wrSelPend_next = 1'b1;
      end else if (wrAge_next == retLat) begin
        wrSelPend_next = 1'b0;
      end
    end
    if (ckFall) begin
      wrSel_next = wrSelPend_reg;
    end
    if (!dynEnable) begin
      wrSelPend_next = 1'b0;
      wrSel_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wrAge_reg <= AGE_IDLE;
      chop_reg <= 1'b0;
      wrSelPend_reg <= 1'b0;
      wrSel_reg <= 1'b0;
    end else begin
      wrAge_reg <= wrAge_next;
      chop_reg <= chop_next;
      wrSelPend_reg <= wrSelPend_next;
      wrSel_reg <= wrSel_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic termActive_reg, termActive_next;
  logic strengthWrite_reg, strengthWrite_next;
  logic [NOM_W-1:0] rtt_reg, rtt_next;

  // drivers active blocks termination, strength picks its code
  always_comb begin
    termActive_next = termOn_reg & ~dqDriving;
    strengthWrite_next = wrSel_reg;
    rtt_next = wrSel_reg ? {1'b0, wrCode_reg} : nomCode_reg;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      termActive_reg <= 1'b0;
      strengthWrite_reg <= 1'b0;
      rtt_reg <= '0;
    end else begin
      termActive_reg <= termActive_next;
      strengthWrite_reg <= strengthWrite_next;
      rtt_reg <= rtt_next;
    end
  end

  assign termActive = termActive_reg;
  assign strengthWrite = strengthWrite_reg;
  assign rttSetting = rtt_reg;
  assign status = {wrSel_reg, termActive_reg, termPend_reg, dynEnable, odtEnable};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_turn_on_lat: assert property (ckRise && odtEnable && delayedOdt |=> termOn_reg)
    else $error("termination not on after turn-on latency");
  chk_turn_off_lat: assert property (ckRise && !delayedOdt |=> !termPend_reg)
    else $error("termination not released after turn-off latency");
  chk_off_half: assert property (termOn_reg && !termPend_reg && !ckFall
    |=> termOn_reg)
    else $error("termination dropped before the half cycle point");
  chk_drive_block: assert property (dqDriving |=> !termActive)
    else $error("termination on while data drivers active");
  chk_dyn_enable: assert property (!dynEnable |=> !wrSel_reg ##1 !strengthWrite)
    else $error("write strength used with dynamic switching off");
  chk_rtt_value: assert property (1 |=> rttSetting == ($past(wrSel_reg) ?
    {1'b0, $past(wrCode_reg)} : $past(nomCode_reg)))
    else $error("termination value from wrong field");
  chk_write_sel: assert property (ckRise && dynEnable && !wrLevel
    && wrAge_reg == termLat - 6'h01 |=> wrSelPend_reg)
    else $error("write strength not selected at latency");
  chk_return_nom: assert property (ckRise && dynEnable && !wrLevel && termLat > 6'h01
    && wrAge_reg == retLat - 6'h01 |=> !wrSelPend_reg)
    else $error("nominal strength not restored");
  chk_odt_ignored: assert property (!odtEnable && !termOn_reg |=> !termOn_reg && !termPend_reg)
    else $error("odt acted on while termination disabled");
  chk_write_restart: assert property (ckRise && wrLevel |=> wrAge_reg == 6'h00)
    else $error("newer write did not restart count");
  chk_nominal_idle: assert property (!wrSel_reg |=> !strengthWrite)
    else $error("write strength outside write window");

  cov_term_on: cover property (termActive && !strengthWrite);
  cov_write_strength: cover property (termActive && strengthWrite);
  cov_restart: cover property (ckRise && wrLevel && wrSelPend_reg);
  cov_drive_block: cover property (termOn_reg && dqDriving);
endmodule : dram_termination_control

// file: hw/odt_pkg.sv
package odt_pkg;
  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_NOM_CODE = 8'h00;
  localparam logic [7:0] OFF_WR_CODE = 8'h04;
  localparam logic [7:0] OFF_CWL = 8'h08;
  localparam logic [7:0] OFF_AL = 8'h0c;
  localparam logic [7:0] OFF_BURST = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int NOM_W = 3;            // nominal strength {a9,a6,a2}
  localparam int WRC_W = 2;            // write strength {a10,a9}
  localparam int LAT_W = 6;
  localparam int CFG_W = 4;
  localparam logic [2:0] RST_NOM_CODE = 3'h0;
  localparam logic [1:0] RST_WR_CODE = 2'h0;
  localparam logic [3:0] RST_CWL = 4'h5;
  localparam logic [3:0] RST_AL = 4'h0;
  localparam logic [1:0] RST_BURST = 2'h0;
  localparam int STAT_W = 5;

  // burst mode encodings
  localparam logic [1:0] BURST_FIXED8 = 2'h0;
  localparam logic [1:0] BURST_OTF = 2'h1;
  localparam logic [1:0] BURST_FIXED4 = 2'h2;

  // ----------------------------------------------------------------
  // latencies in link clock cycles
  // ----------------------------------------------------------------
  localparam logic [5:0] LAT_OFFSET = 6'h02;   // termination latency = wl - 2
  localparam logic [5:0] TAIL_CHOP = 6'h04;    // write window extra, chopped burst
  localparam logic [5:0] TAIL_FULL = 6'h06;    // write window extra, full burst
  localparam logic [5:0] AGE_IDLE = 6'h3f;     // write age when no write pending
  localparam int ODT_MIN_HIGH_BC4 = 4;
  localparam int ODT_MIN_HIGH_BL8 = 6;
endpackage : odt_pkg

// file: hw/pin_sync.sv
// three-stage sampler: a change counts once stages two and three agree
module pin_sync (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    stage_next = {stage_reg[1:0], pinIn};
    level_next = level_reg;
    if (stage_reg[1] == stage_reg[2]) begin
      level_next = stage_reg[2];
    end
  end

  // stage 0 feeds only stage 1
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stage_reg <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
  assign rise = level_next & ~level_reg;
  assign fall = ~level_next & level_reg;
endmodule : pin_sync

// file: tb/ddr_ctrl_model.sv
// memory controller side: link clock and the odt, write and burst pins
module ddr_ctrl_model (
  input wire logic core_clk,
  output logic linkClk,
  output logic odtPin,
  output logic writeCmdPin,
  output logic burstSelPin
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // link clock
  // ----------------------------------------------------------------
  // free-running dram clock, phase unrelated to core_clk
  initial begin
    linkClk = 1'b0;
    odtPin = 1'b0;
    writeCmdPin = 1'b0;
    burstSelPin = 1'b0;
    #7.3;
    forever #40 linkClk = ~linkClk;
  end

  // ----------------------------------------------------------------
  // one link cycle of pin values
  // ----------------------------------------------------------------
  // called at a link fall (at a rise in the read phase); pins settle half or a whole link cycle before the rise
  task automatic link_cycle(input logic odt, input logic wr, input logic sel);
    @(posedge core_clk);
    odtPin <= odt;
    writeCmdPin <= wr;
    burstSelPin <= wr ? sel : ~sel; // no stale burst value between writes
    @(posedge linkClk);
  endtask : link_cycle
endmodule : ddr_ctrl_model

// file: tb/test_dram_termination_control.sv
// randomised termination latency and write strength checks
module test_dram_termination_control;
  import odt_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic dqDriving = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic [DATA_W-1:0] regRdData;
  logic linkClk, odtPin, writeCmdPin, burstSelPin, termActive, strengthWrite;
  logic [NOM_W-1:0] rttSetting;
  int errors = 0;
  int samplesChecked = 0;
  int seedVal;

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  dram_termination_control dram_termination_control_inst (
    .core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .linkClk(linkClk), .odtPin(odtPin), .writeCmdPin(writeCmdPin),
    .burstSelPin(burstSelPin), .dqDriving(dqDriving), .termActive(termActive),
    .strengthWrite(strengthWrite), .rttSetting(rttSetting)
  );

  ddr_ctrl_model ddr_ctrl_model_inst (
    .core_clk(core_clk), .linkClk(linkClk), .odtPin(odtPin),
    .writeCmdPin(writeCmdPin), .burstSelPin(burstSelPin)
  );

  // ----------------------------------------------------------------
  // compare, report and register bus tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= addr;
    regWrData <= data;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask : reg_wr

  // read data stands in the cycle after the strobe, zero after that
  task automatic reg_rd(input logic [7:0] addr, input logic [31:0] exp, input string name);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= addr;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 check(name, regRdData, exp);
    @(posedge core_clk);
    #1 check({name, " idle"}, regRdData, 32'h0);
  endtask : reg_rd

  // ----------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------
  function automatic logic inRange(input int k, input int lo, input int hi);
    return (k >= lo) && (k <= hi);
  endfunction : inRange

  // extra write-window cycles for the burst length in force at the write
  function automatic int tailOf(input logic [1:0] mode, input logic sel);
    if (mode == BURST_FIXED8 || (mode == BURST_OTF && sel)) begin
      return int'(TAIL_FULL);
    end
    return int'(TAIL_CHOP);
  endfunction : tailOf

  // hang guard
  initial begin
    #300000;
    errors++;
    $display("[ERR] watchdog expected end seen hang");
    complete_run();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int lat, tl, lastW, hold;
    logic [3:0] cwl, al;
    logic [2:0] nom;
    logic [1:0] wr, mode;
    logic sel, two, en, dyn, tExp, sExp;
    seedVal = $urandom(23915);
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    // reset values, unmapped and read-only places
    reg_rd(OFF_NOM_CODE, 32'h0, "nomCode");
    reg_rd(OFF_WR_CODE, 32'h0, "wrCode");
    reg_rd(OFF_CWL, {28'h0, RST_CWL}, "cwl");
    reg_rd(OFF_AL, 32'h0, "al");
    reg_rd(OFF_BURST, 32'h0, "burst");
    reg_wr(8'h18, 32'hffffffff);
    reg_rd(8'h18, 32'h0, "unmapped");
    reg_wr(OFF_STATUS, 32'hffffffff);
    reg_rd(OFF_STATUS, 32'h0, "status");
    for (int it = 0; it < 12; it++) begin
      cwl = 4'(5 + $urandom % 4);
      al = 4'($urandom % 3);
      nom = (it == 0) ? 3'h0 : 3'(1 + $urandom % 7);
      wr = (it == 0 || it % 4 == 3) ? 2'h0 : 2'(1 + $urandom % 3);
      mode = 2'(it % 3);
      sel = 1'($urandom % 2);
      two = 1'(it % 2);
      lat = cwl + al - 2;
      tl = tailOf(mode, sel);
      lastW = two ? lat + 1 : 0;
      hold = lastW + tl + 1;
      en = (nom != 3'h0) || (wr != 2'h0);
      dyn = wr != 2'h0;
      reg_wr(OFF_NOM_CODE, {29'h0, nom});
      reg_wr(OFF_WR_CODE, {30'h0, wr});
      reg_wr(OFF_CWL, {28'h0, cwl});
      reg_wr(OFF_AL, {28'h0, al});
      reg_wr(OFF_BURST, {30'h0, mode});
      reg_rd(OFF_CWL, {28'h0, cwl}, "cwl back");
      reg_rd(OFF_STATUS, {30'h0, dyn, en}, "status");
      @(negedge linkClk);
      // odt from rise 0, writes at rise 0 and, on odd passes, inside the open window
      for (int k = 0; k < hold + lat + tl + 4; k++) begin
        ddr_ctrl_model_inst.link_cycle(k < hold, k == 0 || (two && k == lastW), sel);
        tExp = en && inRange(k, lat + 1, hold + lat);
        sExp = dyn && inRange(k, lat + 1, lastW + lat + tl);
        check("termActive rise", termActive, tExp);
        check("strengthWrite rise", strengthWrite, sExp);
        if (tExp) check("rttSetting", rttSetting, sExp ? {1'b0, wr} : nom);
        @(negedge linkClk);
        check("termActive fall", termActive, en && inRange(k, lat, hold + lat));
        check("strengthWrite fall", strengthWrite, sExp);
      end
    end
    // read: drivers start while termination is off, odt turn-on lands while driving
    @(posedge core_clk);
    dqDriving <= 1'b1;
    for (int k = 0; k < lat + 8; k++) begin
      ddr_ctrl_model_inst.link_cycle(1'b1, 1'b0, 1'b0);
      if (k == lat + 2) begin
        check("termActive driving", termActive, 1'b0);
        @(posedge core_clk);
        dqDriving <= 1'b0;
      end
      if (k == lat + 6) check("termActive released", termActive, 1'b1);
    end
    for (int k = 0; k < lat + 4; k++) begin
      ddr_ctrl_model_inst.link_cycle(1'b0, 1'b0, 1'b0);
    end
    check("termActive final", termActive, 1'b0);
    complete_run();
  end
endmodule : test_dram_termination_control
